// ===== inc/swrst_pkg.sv
// Constants, types and register map of the switch reset and mode block.
// Assumes a 250 MHz system clock and AXI4-Lite register access.
package swrst_pkg;

   // ==================================================
   // Register map, byte addresses
   localparam logic [7:0] SWITCH_CONTROL_REGISTER_OFFSET  = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] MODE_OFFSET   = 8'h08;

   // ==================================================
   // Field positions
   localparam int HALT_BIT        = 0;
   localparam int ST_STATE_LSB    = 0;
   localparam int ST_CODE_LSB     = 4;
   localparam int ST_VALID_BIT    = 8;
   localparam int ST_RESERVED_BIT = 9;
   localparam int ST_PART_LSB     = 16;

   // ==================================================
   // Reset values and bus answers
   localparam logic       HALT_RESET = 1'b0;
   localparam logic [3:0] CODE_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==================================================
   // Mode codes
   localparam logic [3:0] CODE_SP        = 4'h0;
   localparam logic [3:0] CODE_SP_EE     = 4'h1;
   localparam logic [3:0] CODE_SP_JUMP0  = 4'h2;
   localparam logic [3:0] CODE_SP_JUMP1  = 4'h3;
   localparam logic [3:0] CODE_SP_RL     = 4'h8;
   localparam logic [3:0] CODE_SP_RL_EE  = 4'h9;
   localparam logic [3:0] CODE_MP_UA     = 4'hA;
   localparam logic [3:0] CODE_MP_UA_I2C = 4'hB;
   localparam logic [3:0] CODE_MP_UA_EE  = 4'hC;
   localparam logic [3:0] CODE_MP_DIS    = 4'hD;
   localparam logic [3:0] CODE_MP_DIS_EE = 4'hF;

   // Decoded operating mode; the first field is the top bit
   typedef struct packed {
      logic reserved;
      logic disabled_ports;
      logic i2c_reset;
      logic unattached;
      logic reduced_latency;
      logic jump1;
      logic jump0;
      logic eeprom_init;
      logic multi_partition;
   } mode_t;

   localparam mode_t MODE_RESET = '0;

   typedef enum logic [1:0] {
      ST_RESET,
      ST_HALT,
      ST_RUN
   } rst_state_t;

endpackage : swrst_pkg

// ===== inc/mode_if.sv
// Carrier between the reset sequencer and the mode decoder.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface mode_if;
   logic                 sample;
   logic                 clear;
   logic [3:0]           code;
   logic [3:0]           code_held;
   logic                 valid;
   swrst_pkg::mode_t     mode;

   modport seq (output sample, output clear, output code,
                input code_held, input valid, input mode);
   modport dec (input sample, input clear, input code,
                output code_held, output valid, output mode);
endinterface : mode_if

// ===== rtl/mode_decoder.sv
// Mode-select decoder with hold register.
// Assumes code is already synchronised and sample is a one-cycle pulse.
`timescale 1ns/10ps
module mode_decoder (
   // Clock and reset
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic ce,
   // Sequencer side
   mode_if.dec       mif
);

   // ==================================================
   // Decode function
   function automatic swrst_pkg::mode_t decode(input logic [3:0] c);
      swrst_pkg::mode_t m;
      m = swrst_pkg::MODE_RESET;
      unique case (c)
         swrst_pkg::CODE_SP: ;
         swrst_pkg::CODE_SP_EE: m.eeprom_init = 1'b1;
         swrst_pkg::CODE_SP_JUMP0: m.jump0 = 1'b1;
         swrst_pkg::CODE_SP_JUMP1: m.jump1 = 1'b1;
         swrst_pkg::CODE_SP_RL: m.reduced_latency = 1'b1;
         swrst_pkg::CODE_SP_RL_EE: begin
            m.reduced_latency = 1'b1;
            m.eeprom_init     = 1'b1;
         end
         swrst_pkg::CODE_MP_UA: begin
            m.multi_partition = 1'b1;
            m.unattached      = 1'b1;
         end
         swrst_pkg::CODE_MP_UA_I2C: begin
            m.multi_partition = 1'b1;
            m.unattached      = 1'b1;
            m.i2c_reset       = 1'b1;
         end
         swrst_pkg::CODE_MP_UA_EE: begin
            m.multi_partition = 1'b1;
            m.unattached      = 1'b1;
            m.i2c_reset       = 1'b1;
            m.eeprom_init     = 1'b1;
         end
         swrst_pkg::CODE_MP_DIS: begin
            m.multi_partition = 1'b1;
            m.disabled_ports  = 1'b1;
         end
         swrst_pkg::CODE_MP_DIS_EE: begin
            m.multi_partition = 1'b1;
            m.disabled_ports  = 1'b1;
            m.eeprom_init     = 1'b1;
         end
         // 0x4-0x7 and 0xE flagged so software can see a bad strap
         default: m.reserved = 1'b1;
      endcase
      return m;
   endfunction : decode

   swrst_pkg::mode_t mode_ff,  nxt_mode;
   logic [3:0]       code_ff,  nxt_code;
   logic             valid_ff, nxt_valid;

   // ==================================================
   // Capture at release, hold until next reset
   always_comb begin
      nxt_mode  = mode_ff;
      nxt_code  = code_ff;
      nxt_valid = valid_ff;
      if (mif.clear) begin
         nxt_mode  = swrst_pkg::MODE_RESET;
         nxt_code  = swrst_pkg::CODE_RESET;
         nxt_valid = 1'b0;
      end else if (mif.sample) begin
         nxt_mode  = decode(mif.code);
         nxt_code  = mif.code;
         nxt_valid = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_ff  <= swrst_pkg::MODE_RESET;
         code_ff  <= swrst_pkg::CODE_RESET;
         valid_ff <= 1'b0;
      end else if (ce) begin
         mode_ff  <= nxt_mode;
         code_ff  <= nxt_code;
         valid_ff <= nxt_valid;
      end
   end

   assign mif.mode      = mode_ff;
   assign mif.code_held = code_ff;
   assign mif.valid     = valid_ff;

endmodule : mode_decoder

// ===== rtl/switch_reset_mode_control.sv
// Fundamental reset sequencer with reset-halt and switch mode capture.
// Assumes pins are asynchronous to clock; registers reached by AXI4-Lite.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module switch_reset_mode_control #(
   parameter int NUM_PART = 4
) (
   // Clock, reset, enable
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                ce,
   // Board pins
   input  wire logic                fundamental_reset_n,
   input  wire logic                reset_halt_request,
   input  wire logic [3:0]          switch_mode_select,
   input  wire logic [NUM_PART-1:0] partition_reset_n,
   // Core controls
   output logic                     core_reset_n,
   output logic                     smbus_enable,
   output logic [NUM_PART-1:0]      partition_core_reset_n,
   output swrst_pkg::mode_t         switch_mode,
   output logic                     switch_mode_valid,
   // AXI4-Lite write
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);

   localparam int SW = 6 + NUM_PART;

   mode_if mif ();

   mode_decoder u_dec (
      .clock (clock),
      .nrst  (nrst),
      .ce    (ce),
      .mif   (mif)
   );

   // ==================================================
   // Pin synchronisers
   // Stage one is read only by stage two
   logic [SW-1:0] sync1_ff, sync2_ff;
   logic [SW-1:0] nxt_sync1;
   logic          frst_n_s, halt_req_s;
   logic [3:0]    mode_sel_s;
   logic [NUM_PART-1:0] part_n_s;

   always_comb begin
      nxt_sync1 = {partition_reset_n, switch_mode_select,
                   reset_halt_request, fundamental_reset_n};
   end

   // Reset value treats the part as held in fundamental reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else if (ce) begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= sync1_ff;
      end
   end

   assign frst_n_s   = sync2_ff[0];
   assign halt_req_s = sync2_ff[1];
   assign mode_sel_s = sync2_ff[5:2];
   assign part_n_s   = sync2_ff[SW-1:6];

   // ==================================================
   // Sequencer state and halt bit
   swrst_pkg::rst_state_t state_ff, nxt_state;
   logic                  halt_ff,  nxt_halt;
   logic                  run_ff,   nxt_run;
   logic                  smb_ff,   nxt_smb;
   logic [NUM_PART-1:0]   part_ff,  nxt_part;
   logic                  sw_clear_halt;

   always_comb begin
      nxt_state   = state_ff;
      nxt_halt    = halt_ff;
      mif.sample  = 1'b0;
      mif.clear   = 1'b0;
      mif.code    = mode_sel_s;
      if (!frst_n_s) begin
         nxt_state = swrst_pkg::ST_RESET;
         nxt_halt  = swrst_pkg::HALT_RESET;
         mif.clear = 1'b1;
      end else begin
         // Software clear first, so a hardware set below wins
         if (sw_clear_halt)
            nxt_halt = 1'b0;
         unique case (state_ff)
            swrst_pkg::ST_RESET: begin
               mif.sample = 1'b1;
               if (halt_req_s) begin
                  nxt_state = swrst_pkg::ST_HALT;
                  nxt_halt  = 1'b1;
               end else begin
                  nxt_state = swrst_pkg::ST_RUN;
               end
            end
            swrst_pkg::ST_HALT: begin
               if (!halt_ff)
                  nxt_state = swrst_pkg::ST_RUN;
            end
            swrst_pkg::ST_RUN: ;
            default: nxt_state = swrst_pkg::ST_RESET;
         endcase
      end
      // Registered outputs follow the next state
      nxt_run  = (nxt_state == swrst_pkg::ST_RUN);
      nxt_smb  = (nxt_state != swrst_pkg::ST_RESET);
      nxt_part = {NUM_PART{nxt_run}} & part_n_s;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= swrst_pkg::ST_RESET;
         halt_ff  <= swrst_pkg::HALT_RESET;
         run_ff   <= 1'b0;
         smb_ff   <= 1'b0;
         part_ff  <= '0;
      end else if (ce) begin
         state_ff <= nxt_state;
         halt_ff  <= nxt_halt;
         run_ff   <= nxt_run;
         smb_ff   <= nxt_smb;
         part_ff  <= nxt_part;
      end
   end

   assign core_reset_n           = run_ff;
   assign smbus_enable           = smb_ff;
   assign partition_core_reset_n = part_ff;
   assign switch_mode            = mif.mode;
   assign switch_mode_valid      = mif.valid;

   // ==================================================
   // AXI4-Lite write channel
   // Address and data held separately, so either may come first
   logic        aw_ff, nxt_aw;
   logic        w_ff,  nxt_w;
   logic [7:0]  awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd;
   logic [3:0]  ws_ff, nxt_ws;
   logic        bv_ff, nxt_bv;
   logic [1:0]  br_ff, nxt_br;
   logic        do_write;

   assign s_axi_awready = !aw_ff && !bv_ff;
   assign s_axi_wready  = !w_ff && !bv_ff;
   assign do_write      = aw_ff && w_ff && !bv_ff;
   // Writing zero into the halt field clears it; writing one does nothing
   assign sw_clear_halt = do_write && awa_ff == swrst_pkg::SWITCH_CONTROL_REGISTER_OFFSET
                          && ws_ff[0] && !wd_ff[swrst_pkg::HALT_BIT];

   always_comb begin
      nxt_aw  = aw_ff;
      nxt_w   = w_ff;
      nxt_awa = awa_ff;
      nxt_wd  = wd_ff;
      nxt_ws  = ws_ff;
      nxt_bv  = bv_ff;
      nxt_br  = br_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw  = 1'b1;
         nxt_awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w  = 1'b1;
         nxt_wd = s_axi_wdata;
         nxt_ws = s_axi_wstrb;
      end
      if (do_write) begin
         nxt_aw = 1'b0;
         nxt_w  = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = is_mapped(awa_ff) ? swrst_pkg::RESP_OKAY
                                    : swrst_pkg::RESP_SLVERR;
      end else if (bv_ff && s_axi_bready) begin
         nxt_bv = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         aw_ff  <= 1'b0;
         w_ff   <= 1'b0;
         awa_ff <= '0;
         wd_ff  <= '0;
         ws_ff  <= '0;
         bv_ff  <= 1'b0;
         br_ff  <= swrst_pkg::RESP_OKAY;
      end else if (ce) begin
         aw_ff  <= nxt_aw;
         w_ff   <= nxt_w;
         awa_ff <= nxt_awa;
         wd_ff  <= nxt_wd;
         ws_ff  <= nxt_ws;
         bv_ff  <= nxt_bv;
         br_ff  <= nxt_br;
      end
   end

   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp  = br_ff;

   // ==================================================
   // Address decode for the write response; reads decode in their own case
   function automatic logic is_mapped(input logic [7:0] a);
      return a == swrst_pkg::SWITCH_CONTROL_REGISTER_OFFSET || a == swrst_pkg::STATUS_OFFSET
             || a == swrst_pkg::MODE_OFFSET;
   endfunction : is_mapped

   // ==================================================
   // AXI4-Lite read channel
   logic        rv_ff, nxt_rv;
   logic [31:0] rd_ff, nxt_rd;
   logic [1:0]  rr_ff, nxt_rr;
   logic [31:0] status_word;

   assign s_axi_arready = !rv_ff;

   always_comb begin
      status_word = '0;
      status_word[swrst_pkg::ST_STATE_LSB +: 2] = state_ff;
      status_word[swrst_pkg::ST_CODE_LSB +: 4]  = mif.code_held;
      status_word[swrst_pkg::ST_VALID_BIT]      = mif.valid;
      status_word[swrst_pkg::ST_RESERVED_BIT]   = mif.mode.reserved;
      status_word[swrst_pkg::ST_PART_LSB +: NUM_PART] = part_n_s;
   end

   always_comb begin
      nxt_rv = rv_ff;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rv = 1'b1;
         nxt_rr = swrst_pkg::RESP_OKAY;
         nxt_rd = '0;
         unique case (s_axi_araddr)
            swrst_pkg::SWITCH_CONTROL_REGISTER_OFFSET:
               nxt_rd[swrst_pkg::HALT_BIT] = halt_ff;
            swrst_pkg::STATUS_OFFSET: nxt_rd = status_word;
            swrst_pkg::MODE_OFFSET:
               nxt_rd[$bits(swrst_pkg::mode_t)-1:0] = mif.mode;
            default: nxt_rr = swrst_pkg::RESP_SLVERR;
         endcase
      end else if (rv_ff && s_axi_rready) begin
         nxt_rv = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rv_ff <= 1'b0;
         rd_ff <= '0;
         rr_ff <= swrst_pkg::RESP_OKAY;
      end else if (ce) begin
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         rr_ff <= nxt_rr;
      end
   end

   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata  = rd_ff;
   assign s_axi_rresp  = rr_ff;

endmodule : switch_reset_mode_control

// ===== tb/switch_reset_mode_control_checker.sv
// Port-level assertions for the switch reset and mode block.
// Assumes ce is held high and one system clock domain.
`timescale 1ns/10ps
module switch_reset_mode_control_checker #(
   parameter int NUM_PART = 4
) (
   // Clock and reset
   input wire logic                clock,
   input wire logic                nrst,
   // Board pins
   input wire logic                fundamental_reset_n,
   input wire logic [NUM_PART-1:0] partition_reset_n,
   // Core controls
   input wire logic                core_reset_n,
   input wire logic                smbus_enable,
   input wire logic [NUM_PART-1:0] partition_core_reset_n,
   input wire swrst_pkg::mode_t    switch_mode,
   input wire logic                switch_mode_valid,
   // Register bus handshakes
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // ==================================================
   // Reset, halt and mode
   // Three low samples cover the two-flop synchroniser plus one edge
   a_freset_clears: assert property (
      !fundamental_reset_n [*3]
      |=> !core_reset_n && !smbus_enable && !switch_mode_valid)
      else $error("core still active in fundamental reset");
   a_run_has_smbus: assert property (
      core_reset_n |-> smbus_enable)
      else $error("running without SMBus alive");
   // Leaving halt needs a completed register write
   a_halt_exit: assert property (
      $rose(core_reset_n) |-> !$past(smbus_enable) || $past(s_axi_bvalid))
      else $error("halt left without a bus write");
   a_mode_held: assert property (
      switch_mode_valid && $past(switch_mode_valid) |-> $stable(switch_mode))
      else $error("captured mode changed");

   // ==================================================
   // Partition resets
   a_part_release: assert property (
      (fundamental_reset_n && &partition_reset_n) [*3] ##0 core_reset_n
      |=> &partition_core_reset_n)
      else $error("partition held with no request");
   a_part_drop: assert property (
      !partition_reset_n[0] [*3] |=> !partition_core_reset_n[0])
      else $error("partition zero not reset");
   a_part_gated: assert property (
      (partition_core_reset_n & ~{NUM_PART{core_reset_n}}) == '0)
      else $error("partition runs while core in reset");

   // ==================================================
   // Register access
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
endmodule : switch_reset_mode_control_checker

bind switch_reset_mode_control switch_reset_mode_control_checker #(
   .NUM_PART(NUM_PART)) chk_u (
   .clock(clock), .nrst(nrst),
   .fundamental_reset_n(fundamental_reset_n),
   .partition_reset_n(partition_reset_n),
   .core_reset_n(core_reset_n), .smbus_enable(smbus_enable),
   .partition_core_reset_n(partition_core_reset_n),
   .switch_mode(switch_mode), .switch_mode_valid(switch_mode_valid),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ===== tb/board_model.sv
// Board reset logic driving the switch pins.
// Assumes the bench commands it right after a clock edge.
`timescale 1ns/10ps
module board_model (
   // Clock
   input wire logic  clock,
   // Bench commands
   input wire logic  want_reset,
   input wire logic  want_halt,
   input wire logic [3:0] want_code,
   input wire logic [3:0] want_part,
   // Pins
   output logic       fundamental_reset_n,
   output logic       reset_halt_request,
   output logic [3:0] switch_mode_select,
   output logic [3:0] partition_reset_n
);
   // Strap pins move only while reset is held, never after release
   // Pins settle at the first edge, well inside the bench's own reset
   always @(posedge clock) begin
      fundamental_reset_n <= !want_reset;
      partition_reset_n   <= want_part;
      if (want_reset) begin
         reset_halt_request <= want_halt;
         if (want_code[3:2] != 2'b01) begin
            switch_mode_select <= want_code;
         end
      end
   end
endmodule : board_model

// ===== tb/switch_reset_mode_control_tb.sv
// Self-checking bench for the switch reset and mode block.
// Assumes the checker is bound by its own file.
`timescale 1ns/10ps
module switch_reset_mode_control_tb;
   logic        clock, nrst, ce, want_reset, want_halt;
   logic [3:0]  want_code, want_part, switch_mode_select;
   logic [3:0]  partition_reset_n, partition_core_reset_n, s_axi_wstrb;
   logic        fundamental_reset_n, reset_halt_request;
   logic        core_reset_n, smbus_enable, switch_mode_valid;
   swrst_pkg::mode_t switch_mode;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          n_fail, checked;
   logic [3:0]  codes[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                              4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'hE};

   switch_reset_mode_control #(.NUM_PART(4)) dut_u (
      .clock(clock), .nrst(nrst), .ce(ce),
      .fundamental_reset_n(fundamental_reset_n),
      .reset_halt_request(reset_halt_request),
      .switch_mode_select(switch_mode_select),
      .partition_reset_n(partition_reset_n),
      .core_reset_n(core_reset_n), .smbus_enable(smbus_enable),
      .partition_core_reset_n(partition_core_reset_n),
      .switch_mode(switch_mode), .switch_mode_valid(switch_mode_valid),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );
   board_model board_u (
      .clock(clock), .want_reset(want_reset), .want_halt(want_halt),
      .want_code(want_code), .want_part(want_part),
      .fundamental_reset_n(fundamental_reset_n),
      .reset_halt_request(reset_halt_request),
      .switch_mode_select(switch_mode_select),
      .partition_reset_n(partition_reset_n)
   );

   // ==================================================
   // Clock and watchdog
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      test_done();
   end

   // ==================================================
   // Reference model and helpers
   // Decoded mode, bit 0 multi-partition up to bit 8 reserved
   function logic [8:0] exp_mode(input logic [3:0] c);
      case (c)
         4'h0: return 9'h000;
         4'h1: return 9'h002;
         4'h2: return 9'h004;
         4'h3: return 9'h008;
         4'h8: return 9'h010;
         4'h9: return 9'h012;
         4'hA: return 9'h021;
         4'hB: return 9'h061;
         4'hC: return 9'h063;
         4'hD: return 9'h081;
         4'hF: return 9'h083;
         default: return 9'h100;
      endcase
   endfunction : exp_mode
   function logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      checked++;
      if (seen !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk
   task test_done();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // Bounded wait for mode capture
   task wait_valid();
      int n;
      n = 0;
      while (switch_mode_valid !== 1'b1 && n < 20) begin
         @(posedge clock);
         n++;
      end
   endtask : wait_valid

   // ==================================================
   // Register bus master, holds each channel until taken
   task axi_wr(input logic [7:0] a, input logic [31:0] v,
               output logic [1:0] rsp);
      @(posedge clock);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= v;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, output logic [31:0] v,
               output logic [1:0] rsp);
      @(posedge clock);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // Fundamental reset with a strap code, then check the capture
   task freset(input logic [3:0] c, input logic h);
      @(posedge clock);
      want_reset <= 1'b1;
      want_code  <= c;
      want_halt  <= h;
      repeat (6) @(posedge clock);
      chk("core_reset_n", core_reset_n, 0);
      chk("mode_valid", switch_mode_valid, 0);
      want_reset <= 1'b0;
      wait_valid();
      chk("switch_mode", switch_mode, exp_mode(c));
      chk("core_reset_n", core_reset_n, !h);
      chk("smbus_enable", smbus_enable, 1);
      axi_rd(swrst_pkg::MODE_OFFSET, d, r);
      chk("mode reg", d, exp_mode(c));
   endtask : freset

   // ==================================================
   // Main sequence
   initial begin
      {nrst, want_halt, want_code, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
      {n_fail, checked} = '0;
      ce = 1'b1;
      want_reset = 1'b1;
      want_part = 4'hF;
      s_axi_wstrb = 4'hF;
      lfsr = 32'h71F7;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      foreach (codes[i]) freset(codes[i], 1'b0);
      // Halt: registers live, only a cleared bit starts the core
      freset(swrst_pkg::CODE_SP_EE, 1'b1);
      axi_rd(swrst_pkg::SWITCH_CONTROL_REGISTER_OFFSET, d, r);
      chk("halt bit", d[0], 1);
      axi_rd(swrst_pkg::STATUS_OFFSET, d, r);
      chk("state", d[1:0], 1);
      chk("code", d[7:4], 1);
      axi_wr(swrst_pkg::SWITCH_CONTROL_REGISTER_OFFSET, 32'h1, r);
      repeat (3) @(posedge clock);
      chk("core_reset_n", core_reset_n, 0);
      lfsr = lfsr_next(lfsr);
      axi_wr(8'h0C, lfsr, r);
      chk("bresp", r, swrst_pkg::RESP_SLVERR);
      axi_rd(8'h0C, d, r);
      chk("rresp", r, swrst_pkg::RESP_SLVERR);
      chk("rdata", d, 0);
      axi_wr(swrst_pkg::SWITCH_CONTROL_REGISTER_OFFSET, {lfsr[31:1], 1'b0}, r);
      chk("bresp", r, swrst_pkg::RESP_OKAY);
      repeat (2) @(posedge clock);
      chk("core_reset_n", core_reset_n, 1);
      // Random partition resets touch only their own partition
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clock);
         want_part <= lfsr[3:0];
         repeat (5) @(posedge clock);
         chk("part_reset", partition_core_reset_n, lfsr[3:0]);
         chk("core_reset_n", core_reset_n, 1);
      end
      want_part <= 4'hF;
      // Asynchronous reset in mid-run, then recapture
      @(posedge clock);
      nrst <= 1'b0;
      @(posedge clock);
      chk("core_reset_n", core_reset_n, 0);
      chk("smbus_enable", smbus_enable, 0);
      nrst <= 1'b1;
      wait_valid();
      chk("switch_mode", switch_mode, exp_mode(4'h1));
      test_done();
   end
endmodule : switch_reset_mode_control_tb
